/* File: hw/asrc_pkg.sv */
// package for the host-side controller of an async 1k x 4 sram with clear
// assumes a 100 MHz sys_clk; all device pins are plain registered outputs
package asrc_pkg;

  // ==========================================================
  // geometry and timing
  localparam int ASRC_AW = 10;
  localparam int ASRC_DW = 4;
  localparam int ASRC_CLK_PERIOD_NS = 10;
  localparam int ASRC_CLEAR_PULSE_WIDTH_NS = 12;
  localparam int ASRC_CLEAR_CYCLE_TIME_NS = 24;
  localparam int ASRC_STROBE_HOLD_AFTER_CLEAR_NS = 12;
  localparam int ASRC_WRITE_PULSE_NS = 8;
  localparam int ASRC_READ_ACCESS_NS = 12;
  // least times round up to whole cycles
  localparam int ASRC_CLR_LOW_CYC =
    (ASRC_CLEAR_PULSE_WIDTH_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int ASRC_CLR_HOLD_CYC =
    (ASRC_STROBE_HOLD_AFTER_CLEAR_NS + ASRC_CLK_PERIOD_NS - 1)
    / ASRC_CLK_PERIOD_NS;
  localparam int ASRC_CLR_CYC_MIN =
    (ASRC_CLEAR_CYCLE_TIME_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int ASRC_WR_CYC =
    (ASRC_WRITE_PULSE_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam int ASRC_RD_CYC =
    (ASRC_READ_ACCESS_NS + ASRC_CLK_PERIOD_NS - 1) / ASRC_CLK_PERIOD_NS;
  localparam logic [3:0] ASRC_CNT_RST = 4'h0;

  // ==========================================================
  // host command and pin bundle
  typedef enum logic [1:0] {
    ASRC_OP_READ,
    ASRC_OP_WRITE,
    ASRC_OP_CLEAR
  } asrc_op_t;

  typedef struct packed {
    asrc_op_t op;
    logic [ASRC_AW-1:0] addr;
    logic [ASRC_DW-1:0] wdata;
  } asrc_req_t;

  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic oe_n;
    logic array_clear_n;
    logic [ASRC_AW-1:0] addr;
    logic [ASRC_DW-1:0] din;
  } asrc_pins_t;

  localparam asrc_pins_t ASRC_PINS_IDLE = '{
    sel_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1, array_clear_n: 1'b1,
    addr: '0, din: '0};
endpackage

/* File: hw/asrc_ctrl.sv */
// host controller driving an async 1k x 4 sram with array clear
// assumes the device pins are sampled by the sram as plain levels and the
// data outputs arrive synchronous to sys_clk
// Operation
// - data held stable across rising edge ending the write
// - address valid no later than select falls
// - clear low at least 12 ns with select low, strobe high
// - clear cycle at least 24 ns before next access
// - strobe high and address stable 12 ns after clear rises
module asrc_ctrl
  import asrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire asrc_pkg::asrc_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asrc_pkg::ASRC_DW-1:0] rsp_data,
  output asrc_pkg::asrc_pins_t pins,
  input wire logic [asrc_pkg::ASRC_DW-1:0] dout
);
  import asrc_pkg::*;

  // one state per pin phase of an access
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_WRITE, ST_READ, ST_CLR_LOW, ST_CLR_HOLD, ST_DONE
  } asrc_state_t;

  asrc_state_t state_q;
  asrc_req_t cur_q;
  logic [3:0] cnt_q;
  asrc_pins_t pins_q;
  logic ready_q;
  logic rsp_valid_q;
  logic [ASRC_DW-1:0] rsp_data_q;

  // ==========================================================
  // assertion clocking: every check below runs on sys_clk
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // sequencer: one access at a time, pins change only between phases
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      cnt_q <= ASRC_CNT_RST;
      pins_q <= ASRC_PINS_IDLE;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          ready_q <= 1'b1;
          pins_q <= ASRC_PINS_IDLE;
          if (req_valid && ready_q) begin
            ready_q <= 1'b0;
            cur_q <= req;
            // address and data settle one cycle before select falls
            pins_q.addr <= req.addr;
            pins_q.din <= req.wdata;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // select falls now; the op picks which control falls with it
          pins_q.sel_n <= 1'b0;
          cnt_q <= ASRC_CNT_RST;
          case (cur_q.op)
            ASRC_OP_WRITE: begin
              pins_q.wr_n <= 1'b0;
              state_q <= ST_WRITE;
            end
            ASRC_OP_CLEAR: begin
              pins_q.array_clear_n <= 1'b0;
              state_q <= ST_CLR_LOW;
            end
            default: begin
              pins_q.oe_n <= 1'b0;
              state_q <= ST_READ;
            end
          endcase
        end
        ST_WRITE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(ASRC_WR_CYC - 1)) begin
            // strobe rises first, select a cycle later; data still held
            pins_q.wr_n <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_READ: begin
          // wait out the access time, then take the word and drop oe
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(ASRC_RD_CYC)) begin
            rsp_data_q <= dout;
            rsp_valid_q <= 1'b1;
            pins_q.oe_n <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_CLR_LOW: begin
          // hold the clear low for the least pulse width
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(ASRC_CLR_LOW_CYC - 1)) begin
            pins_q.array_clear_n <= 1'b1;
            cnt_q <= ASRC_CNT_RST;
            state_q <= ST_CLR_HOLD;
          end
        end
        ST_CLR_HOLD: begin
          // strobe stays high, address frozen, cycle runs out
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= 4'(ASRC_CLR_HOLD_CYC - 1) &&
              cnt_q + 4'(ASRC_CLR_LOW_CYC) >=
              4'(ASRC_CLR_CYC_MIN - 1)) begin
            state_q <= ST_DONE;
          end
        end
        default: begin
          // deselect with oe high so no read starts
          pins_q.sel_n <= 1'b1;
          pins_q.oe_n <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // outputs come straight from their registers
  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign pins = pins_q;

  // ==========================================================
  // checks on the pins and host-side outputs this controller drives
  // clear only while selected and with the strobe parked high
  a_clear_needs_sel: assert property (
    !pins_q.array_clear_n |-> !pins_q.sel_n && pins_q.wr_n)
    else $error("clear low without select or with strobe low");
  // a write overlapping the clear would race the zeroing
  a_no_wr_in_clr: assert property (
    !pins_q.array_clear_n |-> pins_q.wr_n)
    else $error("write strobe during clear");
  // clear pulse covers the least width in whole cycles
  a_clear_width: assert property (
    $fell(pins_q.array_clear_n) |-> !pins_q.array_clear_n [*2])
    else $error("clear pulse too short");
  // strobe and address parked after the clear ends
  a_clear_hold: assert property (
    $rose(pins_q.array_clear_n) |->
      (pins_q.wr_n && $stable(pins_q.addr)) [*2])
    else $error("strobe or address moved after clear");
  // select stays low through the least clear cycle, 3 cycles from clear falling
  a_clear_cycle: assert property (
    $fell(pins_q.array_clear_n) |-> (!pins_q.sel_n) [*3])
    else $error("clear cycle too short");
  // no new request is accepted before the clear cycle ends
  a_clear_busy: assert property (
    $fell(pins_q.array_clear_n) |-> (!ready_q) [*5])
    else $error("request accepted inside clear cycle");
  // data and address held across the edge that ends the write
  a_write_data: assert property (
    !pins_q.wr_n |=> $stable(pins_q.din) && $stable(pins_q.addr))
    else $error("data moved during write");
  // strobe rises while select is still low, never together
  a_write_end: assert property (
    $rose(pins_q.wr_n) |-> !pins_q.sel_n && pins_q.oe_n)
    else $error("strobe and select rose together or oe low");
  // select only rises after the strobe has already been high
  a_sel_rise: assert property (
    $rose(pins_q.sel_n) |-> $past(pins_q.wr_n))
    else $error("select rose while strobe was low");
  // write window opens with the strobe, output drive stays off
  a_write_oe_off: assert property (
    !pins_q.wr_n |-> !pins_q.sel_n && pins_q.oe_n && pins_q.array_clear_n)
    else $error("strobe low outside a plain write");
  // address settles before select falls
  a_sel_addr: assert property (
    $fell(pins_q.sel_n) |-> $stable(pins_q.addr))
    else $error("address changed as select fell");
  // output enable only in a read, never with strobe low
  a_read_only: assert property (
    !pins_q.oe_n |-> pins_q.wr_n && !pins_q.sel_n)
    else $error("oe low without read conditions");
  // read data is taken a fixed number of cycles after oe falls
  a_read_rsp: assert property (
    $fell(pins_q.oe_n) |-> ##3 rsp_valid_q)
    else $error("read answer not at fixed latency");
  // the read answer is a single-cycle pulse
  a_rsp_pulse: assert property (
    rsp_valid_q |=> !rsp_valid_q)
    else $error("read answer stood more than one cycle");
  // a ready controller parks every control pin high
  a_idle_pins: assert property (
    ready_q |-> pins_q.sel_n && pins_q.wr_n && pins_q.oe_n &&
      pins_q.array_clear_n)
    else $error("control pin active while idle");

  // main scenarios
  c_write: cover property ($rose(pins_q.wr_n));
  c_read: cover property (rsp_valid_q);
  c_clear: cover property ($rose(pins_q.array_clear_n));
  c_clear_read: cover property ($rose(pins_q.array_clear_n) ##[1:40]
    rsp_valid_q);
  c_write_read: cover property ($rose(pins_q.wr_n) ##[1:20] rsp_valid_q);
endmodule

/* File: verification/asrc_sram_model.sv */
// behavioural model of the 1k x 4 static memory with array clear
// assumes its pins come from the host controller and dout feeds it back
module asrc_sram_model
  import asrc_pkg::*;
(
  input wire asrc_pkg::asrc_pins_t pins,
  output logic [asrc_pkg::ASRC_DW-1:0] dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ASRC_DW-1:0] mem [1<<ASRC_AW];
  logic [ASRC_DW-1:0] last_val;
  // ==========================================================
  // power-up contents are junk, not zero; then array update and output
  // path on every pin change, all from one process
  initial begin
    foreach (mem[i]) mem[i] = 4'ha;
    last_val = 4'h0;
    dout = 4'hf;
    forever begin
      @(pins);
      if (!pins.sel_n && !pins.wr_n && pins.array_clear_n)
        mem[pins.addr] = pins.din;
      if (!pins.sel_n && pins.wr_n && !pins.array_clear_n)
        foreach (mem[i]) mem[i] = 4'h0;
      if (!pins.sel_n && pins.wr_n && !pins.oe_n && pins.array_clear_n) begin
        dout = mem[pins.addr];
        last_val = dout;
      end else begin
        dout = ~last_val; // floating outputs show no stale data
      end
    end
  end
endmodule

/* File: verification/async_sram_with_clear_bench.sv */
// self-checking bench for the sram host controller
// assumes the behavioural memory model stands on the pin side
module async_sram_with_clear_bench;
  import asrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  asrc_req_t req = '0;
  logic req_valid = 1'b0;
  logic req_ready, rsp_valid;
  logic [ASRC_DW-1:0] rsp_data, dout, q;
  asrc_pins_t pins;
  int error_cnt = 0;
  int compares = 0;
  // ==========================================================
  // clock, design and memory
  always #5 sys_clk = ~sys_clk;
  asrc_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .pins(pins), .dout(dout));
  asrc_sram_model mem_model (.pins(pins), .dout(dout));
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [17:0] seen,
                       input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one request held until taken; read data returned in d_out
  task automatic send(input asrc_op_t op, input logic [9:0] a,
                      input logic [3:0] d, output logic [3:0] d_out);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{op: op, addr: a, wdata: d};
    req_valid <= 1'b1;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    while (op == ASRC_OP_READ && rsp_valid !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    d_out = rsp_data;
    check("handshake stall", 18'(n >= 40), 18'h0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("pins in reset", pins, ASRC_PINS_IDLE);
    check("rsp_valid in reset", {17'h0, rsp_valid}, 18'h0);
    $display("test reset done");
  endtask
  task automatic t_write_read();
    logic [9:0] adr [3];
    logic [3:0] dat [3];
    adr = '{10'h000, 10'h3ff, 10'h155};
    dat = '{4'h9, 4'h6, 4'hc};
    for (int i = 0; i < 3; i++) send(ASRC_OP_WRITE, adr[i], dat[i], q);
    for (int i = 0; i < 3; i++) begin
      send(ASRC_OP_READ, adr[i], 4'h0, q);
      check("read word", {14'h0, q}, {14'h0, dat[i]});
    end
    send(ASRC_OP_WRITE, 10'h3ff, 4'h1, q);
    send(ASRC_OP_READ, 10'h3ff, 4'h0, q);
    check("overwrite", {14'h0, q}, 18'h1);
    $display("test write read done");
  endtask
  logic [9:0] adr_list [3] = '{10'h000, 10'h3ff, 10'h155};
  task automatic t_clear();
    send(ASRC_OP_CLEAR, 10'h155, 4'h0, q);
    foreach (adr_list[i]) begin
      send(ASRC_OP_READ, adr_list[i], 4'h0, q);
      check("cleared word", {14'h0, q}, 18'h0);
    end
    send(ASRC_OP_WRITE, 10'h155, 4'he, q);
    send(ASRC_OP_READ, 10'h155, 4'h0, q);
    check("write after clear", {14'h0, q}, 18'he);
    $display("test clear done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    t_reset();
    @(posedge sys_clk);
    rst_n <= 1'b1;
    t_write_read();
    t_clear();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    finish_test();
  end
endmodule
